// ---- core/sbrd_consts.svh ----
// Constants for the serial baud rate divider
`ifndef SBRD_CONSTS_SVH
`define SBRD_CONSTS_SVH
`define SBRD_ADDR_TXCS 12'h000
`define SBRD_ADDR_RXCS 12'h004
`define SBRD_ADDR_DIV 12'h008
`define SBRD_ADDR_STAT 12'h00c
`define SBRD_BIT_CLK_SOURCE 7
`define SBRD_BIT_SYNC 4
`define SBRD_BIT_HIGH_SPEED 2
`define SBRD_BIT_PORT_EN 7
`define SBRD_TXCS_WMASK 8'hf5
`define SBRD_RXCS_WMASK 8'hf8
`define SBRD_TXCS_RESET 8'h02
`define SBRD_RXCS_RESET 8'h00
`define SBRD_DIV_RESET 8'h00
`define SBRD_PRE_SYNC 6'd3
`define SBRD_PRE_HIGH 6'd15
`define SBRD_PRE_LOW 6'd63
`define SBRD_SAMPLE_A 6'd6
`define SBRD_SAMPLE_B 6'd7
`define SBRD_SAMPLE_C 6'd8
`endif

// ---- core/sbrd_pkg.sv ----
// Types for the serial baud rate divider
package sbrd_pkg;
    typedef struct packed {
        logic [7:0] txcs;
        logic [7:0] rxcs;
        logic [7:0] div;
        logic [7:0] tmr;
        logic [5:0] pre;
        logic base_tick;
        logic rate_tick;
        logic sclk;
        logic [2:0] rx_sync;
        logic rx_level;
        logic [2:0] votes;
        logic bit_level;
        logic [31:0] prdata;
    } sbrd_state_t;
endpackage

// ---- core/sbrd_top.sv ----
// Baud rate generator with APB registers and majority-vote receive sampling
//
// Implementation choices: the APB register port and the register offsets.
`include "sbrd_consts.svh"
module sbrd_top
    import sbrd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic receive_data_pin,
    output logic rate_tick,
    output logic shift_clk,
    output logic shift_clk_oe,
    output logic rx_bit_level
);
    sbrd_state_t s_q, s_d;
    logic wr, rd, hit, sync_m, master, en;
    logic [5:0] pre_max;

    default clocking sbrd_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    // Sync mode ignores the high-speed bit
    function automatic logic [5:0] prescale_max(input logic [7:0] tx);
        if (tx[`SBRD_BIT_SYNC]) begin
            prescale_max = `SBRD_PRE_SYNC;
        end else if (tx[`SBRD_BIT_HIGH_SPEED]) begin
            prescale_max = `SBRD_PRE_HIGH;
        end else begin
            prescale_max = `SBRD_PRE_LOW;
        end
    endfunction

    assign en = s_q.rxcs[`SBRD_BIT_PORT_EN];
    assign sync_m = s_q.txcs[`SBRD_BIT_SYNC];
    // master when synchronous with internal clock source
    assign master = sync_m & s_q.txcs[`SBRD_BIT_CLK_SOURCE];
    assign hit = paddr == `SBRD_ADDR_TXCS || paddr == `SBRD_ADDR_RXCS ||
                 paddr == `SBRD_ADDR_DIV || paddr == `SBRD_ADDR_STAT;
    assign wr = psel & penable & pwrite & hit;
    assign rd = psel & ~penable & ~pwrite;

    assign pre_max = prescale_max(s_q.txcs);

    always_comb begin
        s_d = s_q;
        s_d.base_tick = 1'b0;
        s_d.rate_tick = 1'b0;
        // Writes land at the access edge, where the master sees pready
        if (wr && paddr == `SBRD_ADDR_TXCS) begin
            s_d.txcs = (pwdata[7:0] & `SBRD_TXCS_WMASK) |
                       (s_q.txcs & ~`SBRD_TXCS_WMASK);
        end
        if (wr && paddr == `SBRD_ADDR_RXCS) begin
            s_d.rxcs = (pwdata[7:0] & `SBRD_RXCS_WMASK) |
                       (s_q.rxcs & ~`SBRD_RXCS_WMASK);
        end
        if (wr && paddr == `SBRD_ADDR_DIV) begin
            s_d.div = pwdata[7:0];
        end
        if (rd) begin
            case (paddr)
                `SBRD_ADDR_TXCS: s_d.prdata = {24'h000000, s_q.txcs};
                `SBRD_ADDR_RXCS: s_d.prdata = {24'h000000, s_q.rxcs};
                `SBRD_ADDR_DIV: s_d.prdata = {24'h000000, s_q.div};
                `SBRD_ADDR_STAT: s_d.prdata = {24'h000000, s_q.tmr};
                default: s_d.prdata = 32'h00000000;
            endcase
        end
        // disabled port holds the timer chain in reset
        if (!en) begin
            s_d.tmr = 8'h00;
            s_d.pre = 6'h00;
            s_d.sclk = 1'b0;
            // Idle line level, so no false low after enable
            s_d.votes = 3'h7;
        end else if (wr && paddr == `SBRD_ADDR_DIV) begin
            s_d.tmr = 8'h00;
            s_d.pre = 6'h00;
        end else begin
            // 8-bit timer, tick every n+1 clocks
            if (s_q.tmr >= s_q.div) begin
                s_d.tmr = 8'h00;
                s_d.base_tick = 1'b1;
            end else begin
                s_d.tmr = s_q.tmr + 8'h01;
            end
            if (s_q.base_tick) begin
                if (s_q.pre >= pre_max) begin
                    s_d.pre = 6'h00;
                    s_d.rate_tick = 1'b1;
                end else begin
                    s_d.pre = s_q.pre + 6'h01;
                end
                // three samples in async mode at prescaler counts 6 to 8, mid-bit only at high speed
                if (!sync_m && (s_q.pre == `SBRD_SAMPLE_A ||
                        s_q.pre == `SBRD_SAMPLE_B ||
                        s_q.pre == `SBRD_SAMPLE_C)) begin
                    s_d.votes = {s_q.votes[1:0], s_q.rx_level};
                end
                // Shift clock toggles at half the synchronous period
                if (sync_m && s_q.pre[0]) begin
                    s_d.sclk = ~s_q.sclk;
                end
            end
            if (s_q.rate_tick) begin
                s_d.bit_level = maj3(s_q.votes);
            end
        end
        // Three-stage pin sync; the level changes once stages two and three agree
        s_d.rx_sync = {s_q.rx_sync[1:0], receive_data_pin};
        if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
            s_d.rx_level = s_q.rx_sync[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{txcs: `SBRD_TXCS_RESET, rxcs: `SBRD_RXCS_RESET,
                     div: `SBRD_DIV_RESET, rx_sync: 3'h7, rx_level: 1'b1,
                     votes: 3'h7, bit_level: 1'b1, default: '0};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign rate_tick = s_q.rate_tick;
    // shift clock is driven only as synchronous master
    assign shift_clk = master & s_q.sclk;
    assign shift_clk_oe = master & en;
    assign rx_bit_level = s_q.bit_level;

    chk_base_tick_wrap: assert property (
        clk_en && en && !wr && s_q.tmr >= s_q.div
        |=> s_q.base_tick)
        else $error("base tick missing after wrap");

    chk_disabled_quiet: assert property (
        clk_en && !en
        |=> !s_q.rate_tick && s_q.tmr == 8'h00)
        else $error("tick while disabled");

    chk_div_write_clear: assert property (
        clk_en && en && wr && paddr == `SBRD_ADDR_DIV
        |=> s_q.tmr == 8'h00 && s_q.pre == 6'h00)
        else $error("timer not cleared by divisor write");

    chk_slave_no_drive: assert property (
        !master
        |-> !shift_clk_oe && !shift_clk)
        else $error("shift clock driven as slave");

    chk_async_high: assert property (
        !sync_m && s_q.txcs[`SBRD_BIT_HIGH_SPEED]
        |-> pre_max == `SBRD_PRE_HIGH)
        else $error("wrong high speed ratio");

    chk_sync_ratio: assert property (
        sync_m
        |-> pre_max == `SBRD_PRE_SYNC)
        else $error("sync ratio wrong");

    chk_async_low: assert property (
        !sync_m && !s_q.txcs[`SBRD_BIT_HIGH_SPEED]
        |-> pre_max == `SBRD_PRE_LOW)
        else $error("wrong low speed ratio");

    chk_majority: assert property (
        clk_en && en && !wr && s_q.rate_tick
        |=> s_q.bit_level == maj3($past(s_q.votes)))
        else $error("bit level not majority");

    chk_timer_bound: assert property (
        clk_en && en && !wr && s_q.tmr < s_q.div
        |=> s_q.tmr == $past(s_q.tmr) + 8'h01)
        else $error("timer did not count");

    chk_tick_single: assert property (
        clk_en && s_q.rate_tick
        |=> !s_q.rate_tick)
        else $error("rate tick longer than one cycle");

    chk_tick_needs_base: assert property (
        clk_en && !s_q.base_tick
        |=> !s_q.rate_tick)
        else $error("rate tick without base tick");

    chk_div_value: assert property (
        clk_en && wr && paddr == `SBRD_ADDR_DIV
        |=> {24'h000000, s_q.div} == ($past(pwdata) & 32'h000000ff))
        else $error("divisor not written");

    chk_wrap_zero: assert property (
        clk_en && en && !wr && s_q.tmr >= s_q.div
        |=> s_q.tmr == 8'h00)
        else $error("timer not reloaded");

    chk_pre_step: assert property (
        clk_en && en && !wr && s_q.base_tick && s_q.pre < pre_max
        |=> s_q.pre == $past(s_q.pre) + 6'h01)
        else $error("prescaler did not step");

    chk_rate_on_last: assert property (
        clk_en && en && !wr && s_q.base_tick && s_q.pre >= pre_max
        |=> s_q.rate_tick && s_q.pre == 6'h00)
        else $error("rate tick missing at prescaler end");

    chk_sclk_toggle: assert property (
        clk_en && en && !wr && sync_m && s_q.base_tick && s_q.pre[0]
        |=> s_q.sclk != $past(s_q.sclk))
        else $error("shift clock did not toggle");

    chk_sclk_hold: assert property (
        clk_en && en && !s_q.base_tick
        |=> s_q.sclk == $past(s_q.sclk))
        else $error("shift clock moved without base tick");

    chk_votes_sync: assert property (
        clk_en && en && sync_m
        |=> s_q.votes == $past(s_q.votes))
        else $error("vote taken in sync mode");

    chk_vote_shift: assert property (
        clk_en && en && !wr && !sync_m && s_q.base_tick &&
        s_q.pre == `SBRD_SAMPLE_B |=> s_q.votes[0] == $past(s_q.rx_level))
        else $error("vote not taken from pin");

    chk_level_hold: assert property (
        clk_en && !s_q.rate_tick
        |=> s_q.bit_level == $past(s_q.bit_level))
        else $error("bit level changed without tick");

    chk_disabled_reset: assert property (
        clk_en && !en
        |=> !s_q.sclk && s_q.pre == 6'h00 && s_q.votes == 3'h7)
        else $error("chain not held while disabled");

    chk_pin_sync_hold: assert property (
        clk_en && s_q.rx_sync[1] != s_q.rx_sync[2]
        |=> s_q.rx_level == $past(s_q.rx_level))
        else $error("pin level taken before stages agree");

    chk_read_upper_zero: assert property (
        clk_en && rd
        |=> s_q.prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    chk_fixed_bits: assert property (
        s_q.txcs[3] == 1'b0 && s_q.txcs[1] == 1'b1 &&
        s_q.rxcs[2:0] == 3'h0)
        else $error("read-only bits changed");

    chk_status_read: assert property (
        clk_en && rd && paddr == `SBRD_ADDR_STAT
        |=> s_q.prdata[7:0] == $past(s_q.tmr))
        else $error("status read not timer value");

    // Clock enable freezes state
    chk_clk_en_freeze: assert property (
        !clk_en
        |=> s_q == $past(s_q))
        else $error("state moved while clock enable low");

    // Read data stands until next read
    chk_prdata_hold: assert property (
        clk_en && !rd
        |=> s_q.prdata == $past(s_q.prdata))
        else $error("read data changed without read");
endmodule

// ---- tb/tb_serial_baud_rate_divider.sv ----
// Self-checking bench for the baud rate divider
`include "sbrd_consts.svh"
module tb_serial_baud_rate_divider;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] tx;
        logic [7:0] dv;
        int per;
        logic oe;
    } sbrd_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic rx_pin = 1'b1;
    logic clk_en = 1'b1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rate_tick, shift_clk, shift_clk_oe;
    logic rx_bit_level, err;
    int n_fail = 0;
    int n_checks = 0;
    int p, c;
    // high-speed rows for periods of 96 and 4096 clocks
    // Mode, divisor, tick period in clocks, clock pin driven
    sbrd_row_t rows[7] = '{'{8'h00, 8'h02, 192, 1'b0},
        '{8'h00, 8'h00, 64, 1'b0}, '{8'h04, 8'h05, 96, 1'b0},
        '{8'h04, 8'hff, 4096, 1'b0}, '{8'h10, 8'h03, 16, 1'b0},
        '{8'h94, 8'h03, 16, 1'b1}, '{8'h90, 8'hff, 1024, 1'b1}};

    sbrd_top i_sbrd_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .receive_data_pin(rx_pin),
        .rate_tick(rate_tick), .shift_clk(shift_clk),
        .shift_clk_oe(shift_clk_oe), .rx_bit_level(rx_bit_level));

    always #20 pclk = ~pclk;

    task automatic give_verdict;
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t: read %h, expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t: level %b, expected %b", $time, g, e);
        end
    endtask

    task automatic chkn(input int g, input int e);
        n_checks++;
        if (g != e) begin
            n_fail++;
            $display("Error %0t: count %0d, expected %0d", $time, g, e);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (rate_tick !== 1'b1 && n < 5000);
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        chk1(rate_tick, 1'b0);
        chk1(rx_bit_level, 1'b1);
        presetn <= 1'b1;
        apb(1'b0, `SBRD_ADDR_TXCS, 32'h0);
        chk32(rd, 32'h02);
        apb(1'b0, `SBRD_ADDR_DIV, 32'h0);
        chk32(rd, 32'h00);
        apb(1'b1, `SBRD_ADDR_TXCS, 32'hff);
        apb(1'b0, `SBRD_ADDR_TXCS, 32'h0);
        chk32(rd, 32'hf7);
        apb(1'b0, 12'h010, 32'h0);
        chk32(rd, 32'h0);
        chk1(err, 1'b1);
        apb(1'b1, `SBRD_ADDR_RXCS, 32'h80);
        foreach (rows[i]) begin
            apb(1'b1, `SBRD_ADDR_TXCS, {24'h0, rows[i].tx});
            apb(1'b1, `SBRD_ADDR_DIV, {24'h0, rows[i].dv});
            repeat (3) wait_tick(p);
            chkn(p, rows[i].per);
            chk1(shift_clk_oe, rows[i].oe);
        end
        // divisor rewritten as after a clock change
        apb(1'b1, `SBRD_ADDR_DIV, 32'd200);
        wait_tick(p);
        repeat (20) @(posedge pclk);
        apb(1'b1, `SBRD_ADDR_DIV, 32'd1);
        wait_tick(p);
        // Period 8 plus two cycles of restart, not the old 804
        chkn(p, 10);
        apb(1'b1, `SBRD_ADDR_TXCS, 32'h04);
        apb(1'b1, `SBRD_ADDR_DIV, 32'h0);
        @(posedge pclk) rx_pin <= 1'b0;
        repeat (3) wait_tick(p);
        chk1(rx_bit_level, 1'b0);
        @(posedge pclk) rx_pin <= 1'b1;
        repeat (3) wait_tick(p);
        chk1(rx_bit_level, 1'b1);
        // Frozen time is lost, the period resumes where it stopped
        @(posedge pclk) clk_en <= 1'b0;
        c = 0;
        repeat (50) begin
            @(negedge pclk);
            if (rate_tick !== 1'b0)
                c++;
        end
        chkn(c, 0);
        @(posedge pclk) clk_en <= 1'b1;
        wait_tick(p);
        chkn(p, 16);
        apb(1'b1, `SBRD_ADDR_TXCS, 32'h90);
        apb(1'b1, `SBRD_ADDR_DIV, 32'h0);
        repeat (8) @(posedge pclk);
        c = 0;
        repeat (8) begin
            @(negedge pclk);
            if (shift_clk === 1'b1)
                c++;
        end
        chkn(c, 4);
        apb(1'b1, `SBRD_ADDR_RXCS, 32'h0);
        // A tick launched by the disabling edge itself is allowed
        @(posedge pclk);
        c = 0;
        repeat (300) begin
            @(negedge pclk);
            if (rate_tick !== 1'b0)
                c++;
        end
        chkn(c, 0);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk1(shift_clk_oe, 1'b0);
        presetn <= 1'b1;
        apb(1'b0, `SBRD_ADDR_TXCS, 32'h0);
        chk32(rd, 32'h02);
        give_verdict();
    end
endmodule
